// *** core/tec8_pkg.sv ***
// shared constants for the eight-bit timer/event counter block
package tec8_pkg;

  // register addresses on the cpu data port
  localparam logic [15:0] TEC8_ADDR_PORT2_DIR = 16'hFF22;
  localparam logic [15:0] TEC8_ADDR_MODE_CTRL = 16'hFF53;
  localparam logic [15:0] TEC8_ADDR_MATCH_VAL = 16'hFF50;
  localparam logic [15:0] TEC8_ADDR_COUNT_VAL = 16'hFF51;

  // values after reset
  localparam logic [7:0] TEC8_PORT2_DIR_RESET = 8'hFF;
  localparam logic [7:0] TEC8_MODE_CTRL_RESET = 8'h00;
  localparam logic [7:0] TEC8_MATCH_VAL_RESET = 8'hFF;
  localparam logic [7:0] TEC8_COUNT_VAL_RESET = 8'h00;
  localparam logic [7:0] TEC8_UNMAPPED_READ = 8'h00;

  // mode control field positions
  localparam int TEC8_RUN_BIT = 7;
  localparam int TEC8_PWM_BIT = 6;
  localparam int TEC8_CKSEL_HI_BIT = 2;
  localparam int TEC8_CKSEL_LO_BIT = 1;
  localparam int TEC8_OUT_EN_BIT = 0;
  // writable bits of the mode control register; bits 5..3 read zero
  localparam logic [7:0] TEC8_MODE_CTRL_MASK = 8'hC7;

  // shared pin position inside port 2
  localparam int TEC8_SHARED_PIN_BIT = 7;

  // divided count clock: log2 of the division of the system clock
  localparam int TEC8_DIV_LOG2 = 8;

  // system clock period in ps (200 MHz)
  localparam int TEC8_CLK_PERIOD_PS = 5000;

  // count clock selection codes
  typedef enum logic [1:0] {
    TEC8_CK_SYS = 2'h0,
    TEC8_CK_DIV = 2'h1,
    TEC8_CK_RISE = 2'h2,
    TEC8_CK_FALL = 2'h3
  } tec8_cksel_t;

  // counter operating states, one-hot
  typedef enum logic [2:0] {
    TEC8_ST_STOP = 3'h1,
    TEC8_ST_CLEAR = 3'h2,
    TEC8_ST_PWM = 3'h4
  } tec8_state_t;

endpackage

// *** core/tec8_pin_sync.sv ***
// two-flop synchroniser with edge pulses for the event input pin
`timescale 1ns/1ps
module tec8_pin_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // asynchronous pin
  input wire logic pin,
  // edge pulses, one cycle each
  output logic rise,
  output logic fall
);

  logic meta; // first stage, read only by the second stage
  logic sync; // second stage, safe to use
  logic last; // previous synchronised level
  logic next_rise;
  logic next_fall;

  // edge decode looks only at settled stages
  always_comb begin
    next_rise = sync & ~last;
    next_fall = ~sync & last;
  end

  // synchroniser chain and registered edge pulses
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
      rise <= 1'b0;
      fall <= 1'b0;
    end else if (ce) begin
      meta <= pin;
      sync <= meta;
      last <= sync;
      rise <= next_rise;
      fall <= next_fall;
    end
  end

endmodule // tec8_pin_sync

// *** core/tec8_prescale.sv ***
// divider, held at zero while stopped, giving one tick per 2**DIV_LOG2 system clocks
`timescale 1ns/1ps
module tec8_prescale #(
  parameter int DIV_LOG2 = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // divider runs only while the timer runs, so the first tick is a
  // full period after start
  input wire logic run,
  // one-cycle tick
  output logic tick
);

  logic [DIV_LOG2-1:0] div_cnt; // divider state
  logic [DIV_LOG2-1:0] next_div_cnt;
  logic next_tick;

  // count up, tick on the wrap
  always_comb begin
    if (run) begin
      next_div_cnt = div_cnt + 1'b1;
      next_tick = &div_cnt;
    end else begin
      next_div_cnt = '0;
      next_tick = 1'b0;
    end
  end

  // register divider
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt <= '0;
      tick <= 1'b0;
    end else if (ce) begin
      div_cnt <= next_div_cnt;
      tick <= next_tick;
    end
  end

endmodule // tec8_prescale

// *** core/tec8_timer.sv ***
// eight-bit timer/event counter with compare, pwm and shared pin output
// Functional notes
// R1 - interval timer raises match interrupt each period
// R2 - event mode counts external input pin pulses
// R3 - square wave on output pin from compare
// R4 - pwm mode gives 8-bit resolution output
// R5 - equal counter and compare raises match interrupt
// R6 - compare register takes any 8-bit value
// R7 - software stops timer before changing compare
// R8 - software never loads zero compare in pwm
// R9 - counter readable, cleared to zero by reset
// R10 - run bit low stops and clears counter
// R11 - mode bit selects timer or pwm operation
// R12 - clock select: system, divided, rise, fall
// R13 - output enable bit routes timer to pin
// R14 - external clock selected disables timer output
// R15 - software writes mode control only when stopped
// R16 - software masks match interrupt in pwm mode
// R17 - port direction bits: 0 output, reset all ones
// R18 - software clears latch and direction for output
// R19 - mode control reads zero after reset
// R20 - non-pwm: clear after match, toggle on match
// R21 - pwm: free run, active while count below compare
`timescale 1ns/1ps
module tec8_timer
  import tec8_pkg::*;
#(
  parameter int DIV_LOG2 = TEC8_DIV_LOG2
) (
  // clock, reset and freeze
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // cpu data port
  input wire logic [15:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  // shared pin and its port latch
  input wire logic event_input_pin,
  input wire logic shared_port_latch,
  output logic shared_port_pin_o,
  output logic shared_port_pin_oe,
  // port 2 direction for the other pins
  output logic [7:0] port2_direction_register,
  // interrupt request pulse
  output logic match_interrupt_request
);

  // register file
  logic [7:0] timer_mode_control_register; // mode control
  logic [7:0] match_value_register; // compare value
  logic [7:0] count_value_register; // counter
  logic [7:0] next_mode_ctrl;
  logic [7:0] next_match_val;
  logic [7:0] next_port2_dir;
  logic [7:0] next_rdata;

  // decoded control fields
  logic run_control_bit;
  logic pulse_width_mode_select;
  logic count_clock_select_high;
  logic count_clock_select_low;
  logic output_enable_bit;
  tec8_cksel_t cksel;

  // counting state
  tec8_state_t state;
  tec8_state_t next_state;
  logic [7:0] next_count;
  logic timer_out; // internal timer output level
  logic next_timer_out;
  logic next_irq;
  logic next_pin_o;
  logic next_pin_oe;

  // count sources
  logic div_tick;
  logic ext_rise;
  logic ext_fall;
  logic count_tick;
  logic at_match;

  // address compare, shared by the write and read decoders
  function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
    hit = (a == b);
  endfunction

  // divided system clock source
  // the divider restarts from zero on each start, so the first divided
  // tick comes a full division after the run bit is set
  tec8_prescale #(
    .DIV_LOG2(DIV_LOG2)
  ) tec8_prescale_inst (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .run(run_control_bit),
    .tick(div_tick)
  );

  // event pin synchroniser; pin is outside this clock domain
  tec8_pin_sync tec8_pin_sync_inst (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .pin(event_input_pin),
    .rise(ext_rise),
    .fall(ext_fall)
  );

  // field split of the mode control register
  always_comb begin
    run_control_bit = timer_mode_control_register[TEC8_RUN_BIT];
    pulse_width_mode_select = timer_mode_control_register[TEC8_PWM_BIT];
    count_clock_select_high = timer_mode_control_register[TEC8_CKSEL_HI_BIT];
    count_clock_select_low = timer_mode_control_register[TEC8_CKSEL_LO_BIT];
    output_enable_bit = timer_mode_control_register[TEC8_OUT_EN_BIT];
    cksel = tec8_cksel_t'({count_clock_select_high, count_clock_select_low});
  end

  // count clock selection; the external edges come from the pin
  // synchroniser, so an event is counted three to four clocks after it
  // reaches the pin, and pulses shorter than one clock may be lost
  always_comb begin
    case (cksel)
      TEC8_CK_SYS: count_tick = 1'b1; // R12 R1
      TEC8_CK_DIV: count_tick = div_tick; // R12 R1
      TEC8_CK_RISE: count_tick = ext_rise; // R12 R2
      TEC8_CK_FALL: count_tick = ext_fall; // R12 R2
      default: count_tick = 1'b0;
    endcase
  end

  // register writes and registered reads
  always_comb begin
    next_mode_ctrl = timer_mode_control_register;
    next_match_val = match_value_register;
    next_port2_dir = port2_direction_register;
    next_rdata = bus_rdata;
    if (bus_wr) begin
      if (hit(bus_addr, TEC8_ADDR_MODE_CTRL)) begin
        // reserved bits are never stored, so they read as zero
        next_mode_ctrl = bus_wdata & TEC8_MODE_CTRL_MASK;
      end
      if (hit(bus_addr, TEC8_ADDR_MATCH_VAL)) begin
        // any value is accepted; a rewrite while running may match at
        // once, which software avoids by stopping first
        next_match_val = bus_wdata; // R6 R7
      end
      if (hit(bus_addr, TEC8_ADDR_PORT2_DIR)) begin
        next_port2_dir = bus_wdata; // R17
      end
    end
    if (bus_rd) begin
      if (hit(bus_addr, TEC8_ADDR_MODE_CTRL)) begin
        next_rdata = timer_mode_control_register; // R19
      end else if (hit(bus_addr, TEC8_ADDR_MATCH_VAL)) begin
        next_rdata = match_value_register;
      end else if (hit(bus_addr, TEC8_ADDR_COUNT_VAL)) begin
        next_rdata = count_value_register; // R9
      end else if (hit(bus_addr, TEC8_ADDR_PORT2_DIR)) begin
        next_rdata = port2_direction_register;
      end else begin
        next_rdata = TEC8_UNMAPPED_READ;
      end
    end
  end

  // register file storage; the compare register has no fixed reset
  // value, so it starts at all ones, the longest period, which keeps a
  // timer started without a compare write from firing early
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_mode_control_register <= TEC8_MODE_CTRL_RESET; // R19
      match_value_register <= TEC8_MATCH_VAL_RESET; // R6
      port2_direction_register <= TEC8_PORT2_DIR_RESET; // R17
      bus_rdata <= TEC8_UNMAPPED_READ;
    end else if (ce) begin
      timer_mode_control_register <= next_mode_ctrl;
      match_value_register <= next_match_val;
      port2_direction_register <= next_port2_dir;
      bus_rdata <= next_rdata;
    end
  end

  // counter compare; equality is what raises the request
  // the compare is purely combinational, so a rewrite of the compare
  // register while running can match at once
  always_comb begin
    at_match = (count_value_register == match_value_register); // R5
  end

  // counting state machine
  always_comb begin
    next_count = count_value_register;
    next_timer_out = timer_out;
    next_irq = 1'b0;
    if (!run_control_bit) begin
      next_state = TEC8_ST_STOP;
    end else if (pulse_width_mode_select) begin
      next_state = TEC8_ST_PWM; // R11
    end else begin
      next_state = TEC8_ST_CLEAR; // R11
    end
    case (state)
      TEC8_ST_STOP: begin
        // stopped: counter held at zero, output at its idle level
        next_count = TEC8_COUNT_VAL_RESET; // R10
        next_timer_out = 1'b0;
      end
      TEC8_ST_CLEAR: begin
        // interval, event and square wave: clear on the count after
        // the match, so the period is compare plus one counts
        if (count_tick) begin
          if (at_match) begin
            next_count = TEC8_COUNT_VAL_RESET; // R20 R1 R2
            next_timer_out = ~timer_out; // R20 R3
            next_irq = 1'b1; // R5 R1
          end else begin
            next_count = count_value_register + 8'h01; // R2
          end
        end
      end
      TEC8_ST_PWM: begin
        // free run over 256 counts; the match still raises a request,
        // which software keeps masked in this mode
        if (count_tick) begin
          next_count = count_value_register + 8'h01; // R21 R4
          next_irq = at_match; // R5 R16
        end
        // active level while below compare; a zero compare would hold
        // the output inactive, which software must not rely on
        next_timer_out = (count_value_register < match_value_register); // R21 R4 R8
      end
      default: begin
        next_count = TEC8_COUNT_VAL_RESET;
        next_timer_out = 1'b0;
      end
    endcase
    // a stop takes effect at once: the counter reads zero, the output
    // falls to its idle level and no request leaves in the stop cycle,
    // even though the state register still shows the old mode for one
    // more clock; otherwise a late toggle could reach the pin after the
    // stop and a match in that cycle would raise a stray request
    if (!run_control_bit) begin
      next_count = TEC8_COUNT_VAL_RESET; // R10
      next_timer_out = 1'b0; // R10
      next_irq = 1'b0; // R10
    end
  end

  // counting state storage; the request is registered, high for one cycle
  // per match, and any masking of it sits outside this block
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= TEC8_ST_STOP;
      count_value_register <= TEC8_COUNT_VAL_RESET; // R9
      timer_out <= 1'b0;
      match_interrupt_request <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      count_value_register <= next_count;
      timer_out <= next_timer_out;
      match_interrupt_request <= next_irq;
    end
  end

  // shared pin: timer output, port latch or input
  // the output and enable are registered, so the pin lags the timer
  // output by one clock; this keeps every output straight from a flop
  always_comb begin
    // direction bit 0 turns the buffer on; software also clears the
    // port latch when the pin carries the timer output
    next_pin_oe = ~port2_direction_register[TEC8_SHARED_PIN_BIT]; // R17 R18
    if (output_enable_bit && !count_clock_select_high) begin
      next_pin_o = timer_out; // R13 R3
    end else begin
      next_pin_o = shared_port_latch; // R13
    end
    // the pin doubles as the event input: never drive it when counting
    // external edges with the output enabled
    if (output_enable_bit && count_clock_select_high) begin
      next_pin_oe = 1'b0; // R14
    end
  end

  // pin drivers come from flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      shared_port_pin_o <= 1'b0;
      shared_port_pin_oe <= 1'b0;
    end else if (ce) begin
      shared_port_pin_o <= next_pin_o;
      shared_port_pin_oe <= next_pin_oe;
    end
  end

  // software writes the mode register only while stopped, so a change
  // of clock source never lands mid-count; the logic does not refuse a
  // write while running, it just takes effect on the next clock
  // R15

endmodule // tec8_timer

// *** testbench/tec8_timer_monitor.sv ***
// port-level assertions for the eight-bit timer block
`timescale 1ns/1ps
module tec8_timer_monitor
  import tec8_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // cpu data port
  input wire logic [15:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_wdata,
  input wire logic [7:0] bus_rdata,
  // pin side
  input wire logic shared_port_latch,
  input wire logic shared_port_pin_o,
  input wire logic shared_port_pin_oe,
  input wire logic [7:0] port2_direction_register,
  input wire logic match_interrupt_request
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // shadow of mode control, taken from bus writes only
  logic [7:0] mode_q;
  logic [7:0] next_mode_q;
  always_comb begin
    next_mode_q = mode_q;
    if (ce && bus_wr && bus_addr == TEC8_ADDR_MODE_CTRL) begin
      next_mode_q = bus_wdata;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_q <= 8'h00;
    end else begin
      mode_q <= next_mode_q;
    end
  end
  // named steps, each used by one check only
  sequence s_dir_wr;
    ce && bus_wr && bus_addr == TEC8_ADDR_PORT2_DIR;
  endsequence
  sequence s_bad_rd;
    ce && bus_rd && bus_addr != TEC8_ADDR_PORT2_DIR
      && bus_addr != TEC8_ADDR_MODE_CTRL
      && bus_addr != TEC8_ADDR_MATCH_VAL
      && bus_addr != TEC8_ADDR_COUNT_VAL;
  endsequence
  // three cycles cover the flop of the request after the stop
  sequence s_halted;
    (ce && !mode_q[TEC8_RUN_BIT]) [*3];
  endsequence
  dir_write_a: assert property (s_dir_wr |=>
    port2_direction_register == $past(bus_wdata))
    else $error("direction write not taken");
  rdata_hold_a: assert property (!(ce && bus_rd) |=>
    $stable(bus_rdata)) else $error("read data moved");
  unmapped_read_a: assert property (s_bad_rd |=>
    bus_rdata == TEC8_UNMAPPED_READ) else $error("unmapped read");
  halt_no_irq_a: assert property (s_halted |->
    !match_interrupt_request) else $error("request while stopped");
  ext_no_drive_a: assert property ((ce && mode_q[0] && mode_q[2]) [*2]
    |-> !shared_port_pin_oe) else $error("pin driven on ext clock");
  oe_follow_a: assert property ((ce && !mode_q[2]
    && $stable(port2_direction_register[7])) [*2]
    |-> shared_port_pin_oe == !port2_direction_register[7])
    else $error("pin enable wrong");
  latch_pass_a: assert property ((ce && !mode_q[0]) [*2] |->
    shared_port_pin_o == $past(shared_port_latch))
    else $error("port latch not on pin");
  idle_out_a: assert property ((ce && mode_q[0] && !mode_q[2]
    && !mode_q[7]) [*3] |-> !shared_port_pin_o)
    else $error("timer output not idle");
  freeze_hold_a: assert property (!ce |=>
    $stable(port2_direction_register) && $stable(bus_rdata))
    else $error("flop moved while frozen");
endmodule // tec8_timer_monitor

bind tec8_timer tec8_timer_monitor tec8_timer_monitor_inst (
  .clk, .rst_b, .ce, .bus_addr, .bus_wr, .bus_rd, .bus_wdata,
  .bus_rdata, .shared_port_latch, .shared_port_pin_o,
  .shared_port_pin_oe, .port2_direction_register,
  .match_interrupt_request);

// *** testbench/tec8_event_src.sv ***
// external event source: a burst of pulses on the event pin
`timescale 1ns/1ps
module tec8_event_src (
  // clock and command
  input wire logic clk,
  input wire logic go,
  input wire logic [7:0] n,
  // pin level and burst in progress
  output logic lvl,
  output logic busy
);
  initial begin
    lvl = 1'b0;
    busy = 1'b0;
  end
  // pulses of four cycles each way, long enough for the synchroniser
  always @(posedge go) begin
    busy = 1'b1;
    repeat (n) begin
      repeat (4) @(posedge clk);
      #1 lvl = 1'b1;
      repeat (4) @(posedge clk);
      #1 lvl = 1'b0;
    end
    busy = 1'b0;
  end
endmodule // tec8_event_src

// *** testbench/tec8_timer_test.sv ***
// self-checking bench for the eight-bit timer block
`timescale 1ns/1ps
module tec8_timer_test
  import tec8_pkg::*;
();
  localparam int DIVL = 2; // short divider keeps the run brief
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic latch = 1'b1;
  logic ev_go = 1'b0;
  logic [7:0] ev_n = 8'h00;
  logic [7:0] rdata, dir;
  logic pin_o, pin_oe, irq, ev_lvl, ev_busy;
  // the shared pin: the block wins while it drives
  wire logic pin = pin_oe ? pin_o : ev_lvl;
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 0;
  always #2.5 clk = ~clk;
  tec8_timer #(.DIV_LOG2(DIVL)) tec8_timer_inst (
    .clk, .rst_b, .ce, .bus_addr(addr), .bus_wr(wr), .bus_rd(rd),
    .bus_wdata(wdata), .bus_rdata(rdata), .event_input_pin(pin),
    .shared_port_latch(latch), .shared_port_pin_o(pin_o),
    .shared_port_pin_oe(pin_oe), .port2_direction_register(dir),
    .match_interrupt_request(irq));
  tec8_event_src tec8_event_src_inst (.clk, .go(ev_go), .n(ev_n),
    .lvl(ev_lvl), .busy(ev_busy));
  task automatic final_report();
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // a hang ends the run as a mismatch
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      n_fail++;
      final_report();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // strobes drop and a cycle passes, so calls may follow directly
  task automatic wr8(input logic [15:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    tick(1);
    wr = 1'b0;
    tick(1);
  endtask
  task automatic rchk(input logic [15:0] a, input logic [7:0] e);
    addr = a;
    rd = 1'b1;
    tick(1);
    rd = 1'b0;
    chk({8'h00, rdata}, {8'h00, e});
    tick(1);
  endtask
  // cycles between two match requests, bounded
  task automatic per(output int p);
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 600) begin
      tick(1);
      k++;
    end
    tick(1);
    p = 1;
    while (irq !== 1'b1 && p < 600) begin
      tick(1);
      p++;
    end
  endtask
  task automatic t_reset();
    chk({8'h00, dir}, 16'h00FF);
    rchk(TEC8_ADDR_PORT2_DIR, 8'hFF);
    rchk(TEC8_ADDR_MODE_CTRL, 8'h00);
    rchk(TEC8_ADDR_MATCH_VAL, TEC8_MATCH_VAL_RESET);
    wr8(TEC8_ADDR_MODE_CTRL, 8'h38);
    rchk(TEC8_ADDR_MODE_CTRL, 8'h00);
    wr8(TEC8_ADDR_COUNT_VAL, 8'h5A);
    rchk(TEC8_ADDR_COUNT_VAL, 8'h00);
    rchk(16'hFF60, 8'h00);
    chk({15'h0, pin_o}, 16'h0001);
    $display("test reset done");
  endtask
  task automatic t_interval(input logic [7:0] mode,
                            input logic [7:0] cmp, input int exp);
    int p;
    wr8(TEC8_ADDR_MATCH_VAL, cmp);
    rchk(TEC8_ADDR_MATCH_VAL, cmp);
    wr8(TEC8_ADDR_MODE_CTRL, mode);
    per(p);
    chk(16'(p), 16'(exp));
    wr8(TEC8_ADDR_MODE_CTRL, 8'h00);
    rchk(TEC8_ADDR_COUNT_VAL, 8'h00);
    $display("test interval done");
  endtask
  task automatic t_square();
    logic a;
    latch = 1'b0;
    wr8(TEC8_ADDR_PORT2_DIR, 8'h7F);
    wr8(TEC8_ADDR_MATCH_VAL, 8'h03);
    wr8(TEC8_ADDR_MODE_CTRL, 8'h81);
    tick(10);
    ce = 1'b0;
    tick(5);
    ce = 1'b1;
    chk({15'h0, pin_oe}, 16'h0001);
    a = pin_o;
    tick(4);
    chk({15'h0, pin_o}, {15'h0, ~a});
    tick(4);
    chk({15'h0, pin_o}, {15'h0, a});
    wr8(TEC8_ADDR_MODE_CTRL, 8'h00);
    // stopped with the output enabled: the pin shows the idle level,
    // not the port latch
    latch = 1'b1;
    wr8(TEC8_ADDR_MODE_CTRL, 8'h01);
    tick(2);
    chk({15'h0, pin_o}, 16'h0000);
    latch = 1'b0;
    $display("test square done");
  endtask
  task automatic t_pwm();
    int h;
    wr8(TEC8_ADDR_MATCH_VAL, 8'h40);
    wr8(TEC8_ADDR_MODE_CTRL, 8'hC1);
    tick(20);
    h = 0;
    repeat (256) begin
      h += int'(pin_o === 1'b1);
      tick(1);
    end
    chk(16'(h), 16'h0040);
    wr8(TEC8_ADDR_MODE_CTRL, 8'h00);
    $display("test pwm done");
  endtask
  // the output enable bit stays set: the pin must still be released
  task automatic t_event(input logic [7:0] mode);
    int k;
    wr8(TEC8_ADDR_MATCH_VAL, 8'hFF);
    wr8(TEC8_ADDR_MODE_CTRL, mode);
    ev_n = 8'h05;
    ev_go = 1'b1;
    tick(1);
    ev_go = 1'b0;
    k = 0;
    while (ev_busy !== 1'b0 && k < 100) begin
      tick(1);
      k++;
    end
    tick(8);
    chk({15'h0, pin_oe}, 16'h0000);
    rchk(TEC8_ADDR_COUNT_VAL, 8'h05);
    wr8(TEC8_ADDR_MODE_CTRL, 8'h00);
    $display("test event done");
  endtask
  initial begin
    tick(20);
    rst_b = 1'b1;
    tick(1);
    t_reset();
    t_interval(8'h80, 8'h02, 3);
    t_interval(8'h80, 8'h00, 1);
    t_interval(8'h80, 8'hFF, 256);
    t_interval(8'h82, 8'h01, 2 * (1 << DIVL));
    t_interval(8'hC0, 8'h40, 256);
    t_square();
    t_pwm();
    t_event(8'h85);
    t_event(8'h87);
    final_report();
  end
endmodule // tec8_timer_test
